//--- design/rest_consts.vh
// Constants for the reset entry and test strap block.
`ifndef REST_CONSTS_VH
`define REST_CONSTS_VH
// Number of flops in the pin synchronisers.
`define REST_SYNC_STAGES 2
// Output clock divides the input clock by two.
`define REST_OCLK_DIV 2
// Control outputs driven inactive for this many cycles before floating.
`define REST_DRIVE_INACT_CYC 4'h1
// Width of the abort counter.
`define REST_CNT_W 4
// Reset value of inactive-high control outputs.
`define REST_CTRL_INACTIVE 4'hF
`endif

//--- design/rest_sync2.v
// Two-flop synchroniser for a single level from the pins.
`timescale 1ns/100ps
module rest_sync2 #(
  // Level that both stages take during the internal reset.
  parameter [0:0] SET_VAL = 1'b1
) (
  // Clock and reset.
  input  wire clk_sys,
  input  wire arst_n,
  // Level in and out.
  input  wire dIn,
  output reg  qOut
);
  reg stage1_reg;

  // Both stages take the preset level, so the first reads after power-up are known.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= SET_VAL;
      qOut       <= SET_VAL;
    end else begin
      stage1_reg <= dIn;
      qOut       <= stage1_reg;
    end
  end
endmodule

//--- design/rest_entry_top.v
// Reset entry, bus abort and pin-float test strap logic.
`timescale 1ns/100ps
`include "rest_consts.vh"
module rest_entry_top (
  // Clock and power-on reset.
  input  wire       clk_sys,
  input  wire       arst_n,
  // External reset pin, active low, asynchronous to clk_sys.
  input  wire       external_reset_in_n,
  // Bus cycle state from the bus unit.
  input  wire       busCycleActive,
  input  wire [3:0] busCtrlIn,
  // Strap pin sense and pull-up control.
  input  wire       addr19_test_strap,
  output reg        strapOe,
  output reg        strapPullupEn,
  // Lock and upper address pins, as three-signal two-way pins.
  input  wire       lockPinIn,
  input  wire [2:0] upper_address_bits_in,
  output reg        lockPinOut,
  output reg        lockPinOe,
  output reg  [2:0] upper_address_bits_out,
  output reg  [2:0] upper_address_bits_oe,
  output reg        upperPullupEn,
  // Bus control outputs, active low in the bus sense.
  output reg  [3:0] busCtrlOut,
  output reg        busCtrlOe,
  // Results.
  output reg        output_clock,
  output reg        coreReset,
  output reg        busAbort,
  output reg        pin_float_test_mode
);
  // Abort states, one-hot. Float doubles as the power-on state, so nothing
  // drives the bus until the synchronised reset pin has been seen high.
  localparam ST_RUN   = 3'b001;
  localparam ST_DRIVE = 3'b010;
  localparam ST_FLOAT = 3'b100;

  // Synchronised pins, abort sequencer and release-edge capture.
  wire                   resetSync;
  wire                   strapSync;
  reg  [2:0]             state_reg;
  reg  [2:0]             state_next;
  reg  [`REST_CNT_W-1:0] cnt_reg;
  reg  [`REST_CNT_W-1:0] cnt_next;
  reg                    resetPrev_reg;
  reg                    strapAtRise_reg;

  // True for the running state. Every pin control except strapOe, tied low, keys off the next state
  // so that the pins switch on the same edge as coreReset.
  function is_run;
    input [2:0] st;
    begin
      is_run = (st == ST_RUN);
    end
  endfunction

  // External reset passes two flops before anything reads it. Its flops
  // preset low, so an internal power-on reset never lets the core run
  // before the pin itself has been seen high through both stages.
  rest_sync2 #(
    .SET_VAL (1'b0)
  ) uResetSync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .dIn     (external_reset_in_n),
    .qOut    (resetSync)
  );

  // The strap is only read through its own synchroniser. It presets high,
  // the level that the weak pull-up gives an undriven pin.
  rest_sync2 #(
    .SET_VAL (1'b1)
  ) uStrapSync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .dIn     (addr19_test_strap),
    .qOut    (strapSync)
  );

  // Abort sequencing: drive inactive, then float, stay floated in reset.
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_RUN: begin
        // Any low sample of the synchronised pin starts the abort at ST_DRIVE.
        if (!resetSync) begin
          state_next = ST_DRIVE;
          cnt_next   = `REST_DRIVE_INACT_CYC;
        end
      end
      ST_DRIVE: begin
        // Count down the drive-inactive phase; the last count floats next.
        if (cnt_reg <= 4'h1) begin
          state_next = ST_FLOAT;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      ST_FLOAT: begin
        // Stay floated for as long as the synchronised pin reads low.
        if (resetSync) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        // An illegal code floats the bus, which is the safe side.
        state_next = ST_FLOAT;
      end
    endcase
  end

  // State register; reset-time constants only. The count is cleared here
  // and loaded only on the way into the drive-inactive phase.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_FLOAT;
      cnt_reg   <= {`REST_CNT_W{1'b0}};
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Output clock at half the input rate; it keeps running during reset
  // so the strap hold window can be measured against it.
  // Its phase after reset is fixed low so strap timing is repeatable.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      output_clock <= 1'b0;
    end else begin
      output_clock <= ~output_clock;
    end
  end

  // Bus control pins and core reset. The abort does not wait for the
  // cycle to end, which is the point: reset must win immediately.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busCtrlOut <= `REST_CTRL_INACTIVE;
      busCtrlOe  <= 1'b0;
      coreReset  <= 1'b1;
      busAbort   <= 1'b0;
    end else begin
      coreReset <= !is_run(state_next);
      // The abort pulse lasts one cycle, on the edge that leaves run with a
      // cycle open; the bus unit has to drop that cycle on the pulse.
      busAbort  <= is_run(state_reg) && !resetSync && busCycleActive;
      // Run passes the bus unit's levels, drive holds them inactive, float lets go.
      if (is_run(state_next)) begin
        busCtrlOut <= busCtrlIn;
        busCtrlOe  <= 1'b1;
      end else if (state_next == ST_DRIVE) begin
        busCtrlOut <= `REST_CTRL_INACTIVE;
        busCtrlOe  <= 1'b1;
      end else begin
        busCtrlOut <= `REST_CTRL_INACTIVE;
        busCtrlOe  <= 1'b0;
      end
    end
  end

  // In reset, lock, strap and upper address turn into inputs; only strap and upper address get a pull-up.
  // The out values stay at their idle levels throughout, so the pins come
  // back out of reset without a glitch when the enables rise.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lockPinOut             <= 1'b1;
      lockPinOe              <= 1'b0;
      upper_address_bits_out <= 3'h0;
      upper_address_bits_oe  <= 3'h0;
      upperPullupEn          <= 1'b1;
      strapOe                <= 1'b0;
      strapPullupEn          <= 1'b1;
    end else begin
      lockPinOut             <= 1'b1;
      lockPinOe              <= is_run(state_next);
      upper_address_bits_out <= 3'h0;
      upper_address_bits_oe  <= {3{is_run(state_next)}};
      upperPullupEn          <= !is_run(state_next);
      strapOe                <= 1'b0;
      strapPullupEn          <= !is_run(state_next);
    end
  end

  // Strap captured on the reset release edge and held until the next release edge.
  // Only the last sample taken while reset still reads low counts, so a
  // strap released soon after the pin rises is still seen as low.
  // Lock and upper address sense are left unread on purpose: their level
  // during reset carries no meaning.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      resetPrev_reg       <= 1'b0;
      strapAtRise_reg     <= 1'b1;
      pin_float_test_mode <= 1'b0;
    end else begin
      resetPrev_reg <= resetSync;
      if (!resetSync) begin
        strapAtRise_reg <= strapSync;
      end
      if (resetSync && !resetPrev_reg) begin
        pin_float_test_mode <= !strapAtRise_reg;
      end
    end
  end
endmodule

//--- tb/rest_reset_src.sv
// Model of the board reset source and strap driver.
`timescale 1ns/100ps
module rest_reset_src (
  // Clock and requests from the bench.
  input  wire  clk_sys,
  input  wire  holdReq,
  input  wire  modeReq,
  // Pins driven into the block.
  output logic external_reset_in_n,
  output logic addr19_test_strap
);
  logic [2:0] relCnt = 3'h0;
  // Release is delayed one output clock so the strap is set up first.
  always @(negedge clk_sys) begin
    relCnt <= holdReq ? 3'h0 : (relCnt == 3'h6 ? relCnt : relCnt + 3'h1);
  end
  // Pin is low from time zero until released; a crystal is taken as stable.
  assign external_reset_in_n = !holdReq && relCnt >= 3'h2;
  // Strap is held low across the release, else left to the pull-up.
  assign addr19_test_strap = !(modeReq && relCnt < 3'h6);
endmodule

//--- tb/rest_entry_checker.sv
// Port assertions for the reset entry block.
`timescale 1ns/100ps
module rest_entry_checker (
  // Clock, resets and causes.
  input wire       clk_sys,
  input wire       arst_n,
  input wire       external_reset_in_n,
  input wire       busCycleActive,
  // Pin controls and results.
  input wire       strapPullupEn,
  input wire       upperPullupEn,
  input wire       lockPinOe,
  input wire [2:0] upper_address_bits_oe,
  input wire [3:0] busCtrlOut,
  input wire       busCtrlOe,
  input wire       coreReset,
  input wire       busAbort,
  input wire       pin_float_test_mode
);
  // One clock domain, so one default clock and disable.
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  // Controls go inactive for one cycle, then float.
  sequence s_drain;
    busCtrlOe && busCtrlOut == 4'hF ##1 !busCtrlOe;
  endsequence
  sequence s_pulse;
    busAbort ##1 !busAbort;
  endsequence
  chk_reset_entry: assert property ($fell(external_reset_in_n) |-> ##[1:4] coreReset)
    else $error("reset entry late");
  chk_sync_lag: assert property ($fell(external_reset_in_n) && !coreReset |=> !coreReset)
    else $error("reset not synchronised");
  chk_drive_float: assert property ($rose(coreReset) |-> s_drain)
    else $error("controls not driven inactive");
  chk_float_held: assert property (coreReset [*3] |-> !busCtrlOe)
    else $error("controls not floated");
  chk_abort_pulse: assert property ($rose(coreReset) && $past(busCycleActive) |-> s_pulse)
    else $error("abort pulse wrong");
  chk_abort_cause: assert property (busAbort |-> $rose(coreReset))
    else $error("abort without reset");
  chk_pin_pullups: assert property (coreReset |-> strapPullupEn && upperPullupEn
    && !lockPinOe && upper_address_bits_oe == 3'h0)
    else $error("pins not pulled up");
  chk_mode_stable: assert property (!coreReset [*4] |-> $stable(pin_float_test_mode))
    else $error("mode changed in run");
endmodule
bind rest_entry_top rest_entry_checker chk_u (.clk_sys, .arst_n, .external_reset_in_n,
  .busCycleActive, .strapPullupEn, .upperPullupEn, .lockPinOe, .upper_address_bits_oe,
  .busCtrlOut, .busCtrlOe, .coreReset, .busAbort, .pin_float_test_mode);

//--- tb/test_rest_entry_top.sv
// Testbench for the reset entry and test strap block.
`timescale 1ns/100ps
module test_rest_entry_top;
  logic       clk_sys = 1'b0;
  logic       arst_n = 1'b0;
  logic       holdReq = 1'b1;
  logic       modeReq = 1'b0;
  logic       busCycleActive = 1'b0;
  logic [3:0] busCtrlIn = 4'h5;
  wire        external_reset_in_n, addr19_test_strap, strapOe, strapPullupEn;
  wire        lockPinOut, lockPinOe, upperPullupEn, busCtrlOe, output_clock;
  wire        coreReset, busAbort, pin_float_test_mode;
  wire  [2:0] upper_address_bits_out, upper_address_bits_oe;
  wire  [3:0] busCtrlOut;
  int         n_errors = 0;
  int         n_tests = 0;
  // Released pins sit at the pull-up level; nobody drives them low.
  wire        lockPinIn = lockPinOe ? lockPinOut : 1'b1;
  wire  [2:0] upper_address_bits_in = upper_address_bits_out | ~upper_address_bits_oe;
  always #20 clk_sys = ~clk_sys;
  rest_reset_src src_u (.clk_sys, .holdReq, .modeReq, .external_reset_in_n,
    .addr19_test_strap);
  rest_entry_top dut_u (.clk_sys, .arst_n, .external_reset_in_n, .busCycleActive,
    .busCtrlIn, .addr19_test_strap, .strapOe, .strapPullupEn, .lockPinIn,
    .upper_address_bits_in, .lockPinOut, .lockPinOe, .upper_address_bits_out,
    .upper_address_bits_oe, .upperPullupEn, .busCtrlOut, .busCtrlOe, .output_clock,
    .coreReset, .busAbort, .pin_float_test_mode);
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Bounded wait for the internal reset to reach a level.
  task automatic wait_core(input logic v);
    for (int i = 0; i < 20 && coreReset !== v; i++) @(negedge clk_sys);
    if (coreReset !== v) begin
      n_errors++;
      end_sim();
    end
  endtask
  // Cold start with the pin low from power-on, then a normal release.
  task automatic t_cold();
    logic clkSeen;
    repeat (8) @(negedge clk_sys);
    arst_n = 1'b1;
    // The pin is still low, so the core must stay in reset on every edge.
    repeat (4) begin
      @(negedge clk_sys);
      chk({3'h0, coreReset}, 4'h1);
    end
    holdReq = 1'b0;
    wait_core(1'b0);
    repeat (3) @(negedge clk_sys);
    chk({lockPinOe, upper_address_bits_oe}, 4'hF);
    chk({lockPinOut, upper_address_bits_out}, 4'h8);
    chk({busCtrlOe, strapOe, upperPullupEn, strapPullupEn}, 4'h8);
    chk(busCtrlOut, busCtrlIn);
    chk({3'h0, pin_float_test_mode}, 4'h0);
    clkSeen = output_clock;
    @(negedge clk_sys);
    chk({3'h0, output_clock}, {3'h0, ~clkSeen});
  endtask
  // Warm reset cutting into a bus cycle.
  task automatic t_abort();
    busCycleActive = 1'b1;
    holdReq = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({3'h0, coreReset}, 4'h0);
    wait_core(1'b1);
    chk({busCtrlOe, 2'h0, busAbort}, 4'h9);
    chk(busCtrlOut, 4'hF);
    @(negedge clk_sys);
    chk({busCtrlOe, busAbort, upperPullupEn, strapPullupEn}, 4'h3);
    busCycleActive = 1'b0;
  endtask
  // Strap level at release picks the mode, kept through the run.
  task automatic t_strap(input logic want);
    modeReq = want;
    repeat (4) @(negedge clk_sys);
    holdReq = 1'b0;
    wait_core(1'b0);
    repeat (8) @(negedge clk_sys);
    modeReq = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk({3'h0, pin_float_test_mode}, {3'h0, want});
    holdReq = 1'b1;
    wait_core(1'b1);
  endtask
  initial begin
    t_cold();
    t_abort();
    t_strap(1'b1);
    t_strap(1'b0);
    end_sim();
  end
  // A hang is cut short and counted.
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
endmodule
